// ===== core/low_power_state_controller.sv
`timescale 1ns/1ps
`default_nettype none
`include "lps_consts.svh"

module low_power_state_controller (
  input wire logic clk, // front-side bus clock
  input wire logic resetn, // async processor reset, active low
  input wire logic ce, // clock enable
  input wire logic halt_exec, // core executed halt, pulse
  input wire logic stop_clock_request_n, // pin, active low
  input wire logic sleep_request_n, // pin, active low
  input wire logic deep_sleep_request_n, // pin, active low
  input wire logic sys_mgmt_interrupt_n, // pin, active low
  input wire logic init_request_n, // pin, active low
  input wire logic [1:0] local_interrupt_lines, // pins, active high
  input wire logic bus_int_msg, // bus interrupt message, pulse
  input wire logic snoop_seen, // snoop or interrupt transaction start
  input wire logic snoop_done, // snoop serviced or interrupt latched
  input wire logic grant_ack_resp, // response phase of grant cycle done
  input wire logic interrupt_enable_flag, // core interrupt enable
  input wire logic data_buffer_power_n, // pin, active low
  input wire logic priority_bus_request_n, // pin, active low
  output logic grant_ack_req, // issue grant acknowledge cycle
  output logic core_clk_en, // internal clocks running
  output logic wake_service, // pulse: service pending events
  output lps_pkg::events_s wake_events, // events to service
  output logic pending_break_n, // pin, active low
  output logic power_status_n, // pin, active low
  output lps_pkg::buf_en_s buf_en, // input buffer enables
  output lps_pkg::pstate_e state // current state
);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [8:0] pin_raw;
  logic [8:0] pin_s;

  assign pin_raw = {stop_clock_request_n, sleep_request_n, deep_sleep_request_n,
                    sys_mgmt_interrupt_n, init_request_n, local_interrupt_lines,
                    data_buffer_power_n, priority_bus_request_n};

  lps_sync2 #(
    .W(9),
    .INIT(9'h1f3)
  ) u_sync (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .d(pin_raw),
    .q(pin_s)
  );

  logic stop_clock_request_n_act;
  logic slp_act;
  logic deep_sleep_request_n_act;
  logic smi_act;
  logic init_act;
  logic [1:0] lint_act;
  logic data_buffer_power_n_act;
  logic priority_bus_request_n_act;

  // decode active-low pins to active high
  assign stop_clock_request_n_act = !pin_s[8];
  assign slp_act = !pin_s[7];
  assign deep_sleep_request_n_act = !pin_s[6];
  assign smi_act = !pin_s[5];
  assign init_act = !pin_s[4];
  assign lint_act = pin_s[3:2];
  assign data_buffer_power_n_act = !pin_s[1];
  assign priority_bus_request_n_act = !pin_s[0];

  // ----------------------------------------
  // event edge detection
  // ----------------------------------------
  logic [3:0] lvl_q;
  lps_pkg::events_s ev_now;

  // previous levels for rising edges
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      lvl_q <= 4'h0;
    else if (ce)
      lvl_q <= {lint_act, init_act, smi_act};
  end

  assign ev_now.smi = smi_act && !lvl_q[0];
  assign ev_now.init = init_act && !lvl_q[1];
  assign ev_now.lint0 = lint_act[0] && !lvl_q[2];
  assign ev_now.lint1 = lint_act[1] && !lvl_q[3];
  assign ev_now.bus_int = bus_int_msg;

  // ----------------------------------------
  // state machine
  // ----------------------------------------
  lps_pkg::pstate_e state_q;
  lps_pkg::pstate_e state_d;
  lps_pkg::pstate_e snoop_ret_q;
  logic from_halt_q;
  logic [7:0] grant_cnt_q;
  logic grant_resp_q;
  logic [`LPS_CNT_W-1:0] settle_cnt_q;
  logic latch_en;
  logic consume;
  lps_pkg::events_s pend;

  localparam logic [`LPS_CNT_W-1:0] SETTLE_CLKS = `LPS_CNT_W'(`LPS_PLL_SETTLE_CLKS);

  // next-state decode
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      lps_pkg::st_normal:
      begin
        if (stop_clock_request_n_act)
          state_d = lps_pkg::st_grant_wait;
        else if (halt_exec)
          state_d = lps_pkg::st_halt;
      end
      lps_pkg::st_halt:
      begin
        if (stop_clock_request_n_act)
          state_d = lps_pkg::st_grant_wait;
        else if (snoop_seen)
          state_d = lps_pkg::st_snoop;
        else if (|ev_now)
          state_d = lps_pkg::st_normal;
      end
      lps_pkg::st_grant_wait:
      begin
        if (grant_resp_q && grant_cnt_q == `LPS_GRANT_DELAY_CLKS)
          state_d = lps_pkg::st_stop_grant;
      end
      lps_pkg::st_stop_grant:
      begin
        if (!stop_clock_request_n_act)
          state_d = from_halt_q ? lps_pkg::st_halt : lps_pkg::st_normal;
        else if (slp_act)
          state_d = lps_pkg::st_sleep;
        else if (snoop_seen)
          state_d = lps_pkg::st_snoop;
      end
      lps_pkg::st_snoop:
      begin
        if (snoop_done)
          state_d = snoop_ret_q;
      end
      lps_pkg::st_sleep:
      begin
        if (deep_sleep_request_n_act)
          state_d = lps_pkg::st_deep_sleep;
        else if (!slp_act)
          state_d = lps_pkg::st_stop_grant;
      end
      lps_pkg::st_deep_sleep:
      begin
        if (!deep_sleep_request_n_act)
          state_d = lps_pkg::st_pll_settle;
      end
      lps_pkg::st_pll_settle:
      begin
        if (settle_cnt_q == SETTLE_CLKS)
          state_d = lps_pkg::st_sleep;
      end
      default:
        state_d = lps_pkg::st_normal;
    endcase
  end

  // state register; reset initialises to normal, also from sleep
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state_q <= lps_pkg::st_normal;
    else if (ce)
      state_q <= state_d;
  end

  // snoop return state and halt origin
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      snoop_ret_q <= lps_pkg::st_stop_grant;
      from_halt_q <= 1'b0;
    end
    else if (ce)
    begin
      if (state_q != lps_pkg::st_snoop && state_d == lps_pkg::st_snoop)
        snoop_ret_q <= state_q;
      if (state_q == lps_pkg::st_halt && state_d == lps_pkg::st_grant_wait)
        from_halt_q <= 1'b1;
      else if (state_q == lps_pkg::st_normal)
        from_halt_q <= 1'b0;
    end
  end

  // grant cycle response then 20-clock count
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      grant_resp_q <= 1'b0;
      grant_cnt_q <= 8'h00;
    end
    else if (ce)
    begin
      if (state_q != lps_pkg::st_grant_wait)
      begin
        grant_resp_q <= 1'b0;
        grant_cnt_q <= 8'h00;
      end
      else if (!grant_resp_q)
        grant_resp_q <= grant_ack_resp;
      else if (grant_cnt_q != `LPS_GRANT_DELAY_CLKS)
        grant_cnt_q <= grant_cnt_q + 8'h01;
    end
  end

  // pll settling count after deep sleep
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      settle_cnt_q <= '0;
    else if (ce)
    begin
      if (state_q != lps_pkg::st_pll_settle)
        settle_cnt_q <= '0;
      else if (settle_cnt_q != SETTLE_CLKS)
        settle_cnt_q <= settle_cnt_q + `LPS_CNT_W'(1);
    end
  end

  // ----------------------------------------
  // event latching and service
  // ----------------------------------------
  // latch only in grant states and in a snoop from stop-grant, never in sleep or deep sleep
  assign latch_en = (state_q == lps_pkg::st_grant_wait) || (state_q == lps_pkg::st_stop_grant)
                    || (state_q == lps_pkg::st_snoop && snoop_ret_q == lps_pkg::st_stop_grant);
  assign consume = (state_q == lps_pkg::st_normal) && |pend;

  lps_event_latch u_latch (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .capture(latch_en),
    .ev(ev_now),
    .consume(consume),
    .pending(pend)
  );

  // one-shot service of latched events in normal
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wake_service <= 1'b0;
      wake_events <= '0;
    end
    else if (ce)
    begin
      wake_service <= consume;
      wake_events <= consume ? pend : '0;
    end
  end

  // ----------------------------------------
  // pin outputs
  // ----------------------------------------
  // pending break, regardless of interrupt enable flag
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      pending_break_n <= 1'b1;
    else if (ce)
      pending_break_n <= !((state_q == lps_pkg::st_stop_grant) && |pend);
  end

  // power status follows deep sleep
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      power_status_n <= 1'b1;
    else if (ce)
      power_status_n <= !(state_d == lps_pkg::st_deep_sleep);
  end

  // buffer enables and core clock
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      buf_en <= '0;
      core_clk_en <= 1'b1;
    end
    else if (ce)
    begin
      buf_en.data_in_en <= data_buffer_power_n_act;
      buf_en.addr_ctl_in_en <= priority_bus_request_n_act;
      core_clk_en <= !(state_d == lps_pkg::st_sleep || state_d == lps_pkg::st_deep_sleep
                       || state_d == lps_pkg::st_pll_settle);
    end
  end

  // grant request held until response phase
  assign grant_ack_req = (state_q == lps_pkg::st_grant_wait) && !grant_resp_q;
  assign state = state_q;

  // interrupt enable flag only gates servicing in the core
  logic unused_ok;
  assign unused_ok = interrupt_enable_flag;

endmodule // low_power_state_controller

`default_nettype wire

// ===== include/lps_consts.svh
`ifndef LPS_CONSTS_SVH
`define LPS_CONSTS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define LPS_CLK_PERIOD_NS 100
`define LPS_GRANT_DELAY_CLKS 8'h14
`define LPS_PLL_SETTLE_US 30
`define LPS_PLL_SETTLE_CLKS ((`LPS_PLL_SETTLE_US * 1000 + `LPS_CLK_PERIOD_NS - 1) / `LPS_CLK_PERIOD_NS)
`define LPS_CNT_W 12

// ----------------------------------------
// event vector bit positions
// ----------------------------------------
`define LPS_EV_SMI 0
`define LPS_EV_INIT 1
`define LPS_EV_LINT0 2
`define LPS_EV_LINT1 3
`define LPS_EV_BUSINT 4
`define LPS_EV_W 5

`endif

// ===== include/lps_pkg.sv
`include "lps_consts.svh"
`default_nettype none

package lps_pkg;

  // ----------------------------------------
  // power states
  // ----------------------------------------
  typedef enum logic [2:0] {
    st_normal,
    st_halt,
    st_grant_wait,
    st_stop_grant,
    st_snoop,
    st_sleep,
    st_deep_sleep,
    st_pll_settle
  } pstate_e;

  // ----------------------------------------
  // wake and bus events, active high
  // ----------------------------------------
  typedef struct packed {
    logic bus_int;
    logic lint1;
    logic lint0;
    logic init;
    logic smi;
  } events_s;

  // ----------------------------------------
  // buffer power controls
  // ----------------------------------------
  typedef struct packed {
    logic data_in_en;
    logic addr_ctl_in_en;
  } buf_en_s;

endpackage

`default_nettype wire

// ===== core/lps_sync2.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// two-stage synchroniser, per bit
// ----------------------------------------
module lps_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk, // system clock
  input wire logic resetn, // async reset
  input wire logic ce, // clock enable
  input wire logic [W-1:0] d, // async input
  output logic [W-1:0] q // synchronised output
);

  logic [W-1:0] meta_q;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      // two flops per bit
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
        begin
          meta_q[i] <= INIT[i];
          q[i] <= INIT[i];
        end
        else if (ce)
        begin
          meta_q[i] <= d[i];
          q[i] <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule // lps_sync2

`default_nettype wire

// ===== core/lps_event_latch.sv
`timescale 1ns/1ps
`default_nettype none
`include "lps_consts.svh"

// ----------------------------------------
// sticky latch for wake events
// ----------------------------------------
module lps_event_latch (
  input wire logic clk, // system clock
  input wire logic resetn, // async reset
  input wire logic ce, // clock enable
  input wire logic capture, // latch enable
  input wire lps_pkg::events_s ev, // event pulses
  input wire logic consume, // service latched events
  output lps_pkg::events_s pending // latched events
);

  logic [`LPS_EV_W-1:0] pend_q;

  genvar i;
  generate
    for (i = 0; i < `LPS_EV_W; i++)
    begin : g_ev
      // one occurrence per event; set wins over consume
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          pend_q[i] <= 1'b0;
        else if (ce)
        begin
          if (capture && ev[i])
            pend_q[i] <= 1'b1;
          else if (consume)
            pend_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign pending = lps_pkg::events_s'(pend_q);

endmodule // lps_event_latch

`default_nettype wire

// ===== tb/lps_checker.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// port checker
// ----------------------------------------
module lps_checker (
  input wire logic clk, // bus clock
  input wire logic resetn, // async reset
  input wire logic halt_exec, // halt pulse
  input wire logic bus_int_msg, // bus interrupt
  input wire logic snoop_seen, // snoop start
  input wire logic grant_ack_resp, // grant response
  input wire logic grant_ack_req, // grant cycle
  input wire logic data_buffer_power_n, // data activity
  input wire logic priority_bus_request_n, // priority request
  input wire logic wake_service, // service pulse
  input wire lps_pkg::events_s wake_events, // serviced events
  input wire logic pending_break_n, // break pin
  input wire logic power_status_n, // status pin
  input wire lps_pkg::buf_en_s buf_en, // buffer enables
  input wire lps_pkg::pstate_e state // state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  // grant wait then stop-grant, 22 clocks after the response is sampled
  sequence grant_hold_s;
    (state == lps_pkg::st_grant_wait) [*8];
  endsequence
  sequence grant_end_s;
    (state == lps_pkg::st_grant_wait) ##1 (state == lps_pkg::st_stop_grant);
  endsequence
  property grant_p;
    grant_ack_resp && grant_ack_req |-> ##1 grant_hold_s ##13 grant_end_s;
  endproperty

  AST_HALT_ENTRY: assert property (state == lps_pkg::st_normal && halt_exec |=>
    state inside {lps_pkg::st_halt, lps_pkg::st_grant_wait}) else $error("halt not entered");
  AST_HALT_WAKE: assert property (state == lps_pkg::st_halt && bus_int_msg |=>
    state inside {lps_pkg::st_normal, lps_pkg::st_grant_wait}) else $error("halt not left");
  AST_GRANT_DELAY: assert property (grant_p) else $error("stop-grant delay wrong");
  AST_SNOOP_ENTRY: assert property (state inside {lps_pkg::st_halt, lps_pkg::st_stop_grant} && snoop_seen
    |=> state == lps_pkg::st_snoop) else $error("snoop not entered");
  AST_WAKE_ONCE: assert property (wake_service |-> wake_events != '0 ##1 !wake_service)
    else $error("wake pulse wrong");
  AST_BREAK_SCOPE: assert property (!pending_break_n |-> $past(state) == lps_pkg::st_stop_grant)
    else $error("break outside stop-grant");
  AST_SLEEP_FROM: assert property ($rose(state == lps_pkg::st_sleep) |->
    $past(state) inside {lps_pkg::st_stop_grant, lps_pkg::st_pll_settle}) else $error("bad sleep entry");
  AST_DEEP_FROM: assert property ($rose(state == lps_pkg::st_deep_sleep) |->
    $past(state) == lps_pkg::st_sleep) else $error("bad deep entry");
  AST_STATUS: assert property (!power_status_n == (state == lps_pkg::st_deep_sleep))
    else $error("status pin wrong");
  AST_DATA_BUF: assert property ($stable(data_buffer_power_n) [*4] |->
    buf_en.data_in_en == !data_buffer_power_n) else $error("data buffer enable wrong");
  AST_ADDR_BUF: assert property ($stable(priority_bus_request_n) [*4] |->
    buf_en.addr_ctl_in_en == !priority_bus_request_n) else $error("address buffer enable wrong");
endmodule // lps_checker

`default_nettype wire

// ===== tb/lps_chipset.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// chipset and clock generator model
// ----------------------------------------
module lps_chipset (
  input wire logic clk, // bus clock
  input wire logic resetn, // processor reset
  input wire logic [1:0] target, // wanted depth
  input wire logic [2:0] resp_wait, // response delay
  input wire logic grant_ack_req, // grant cycle
  input wire logic power_status_n, // deep status
  input wire lps_pkg::pstate_e state, // controller state
  output logic stop_clock_request_n, // stop request
  output logic sleep_request_n, // sleep request
  output logic deep_sleep_request_n, // deep request
  output logic grant_ack_resp, // response pulse
  output logic clk_run // clock may run
);
  logic cpu_clock_stop_n;

  // one platform step per clock
  initial
  begin
    {stop_clock_request_n, sleep_request_n, deep_sleep_request_n, cpu_clock_stop_n, clk_run} = 5'h1f;
    grant_ack_resp = 1'b0;
    forever
    begin
      @(posedge clk) #1;
      if (!resetn)
        {stop_clock_request_n, sleep_request_n} = 2'h3;
      else if (grant_ack_req)
      begin
        repeat (resp_wait) @(posedge clk);
        #1 grant_ack_resp = 1'b1;
        @(posedge clk) #1 grant_ack_resp = 1'b0;
      end
      else if (target != 2'h0 && stop_clock_request_n)
        stop_clock_request_n = 1'b0;
      else if (target[1] && sleep_request_n && state == lps_pkg::st_stop_grant)
        sleep_request_n = 1'b0;
      else if (target == 2'h3 && deep_sleep_request_n && state == lps_pkg::st_sleep)
      begin
        {deep_sleep_request_n, cpu_clock_stop_n} = 2'h0;
        for (int i = 0; i < 8 && power_status_n; i++) @(posedge clk);
        clk_run = 1'b0;
        for (int j = 0; j < 1000 && target == 2'h3; j++) #100;
        {deep_sleep_request_n, cpu_clock_stop_n} = 2'h3;
        #400 clk_run = 1'b1;
      end
      else if (!target[1] && !sleep_request_n && state == lps_pkg::st_sleep)
      begin
        sleep_request_n = 1'b1;
        repeat (10) @(posedge clk);
      end
      else if (target == 2'h0 && sleep_request_n && state == lps_pkg::st_stop_grant)
        stop_clock_request_n = 1'b1;
    end
  end
endmodule // lps_chipset

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "lps_consts.svh"

// ----------------------------------------
// testbench top
// ----------------------------------------
module tb;
  logic clk, clk_run, resetn, halt_exec, bus_int_msg, snoop_seen, snoop_done, interrupt_enable_flag;
  logic sys_mgmt_interrupt_n, init_request_n, data_buffer_power_n, priority_bus_request_n;
  logic stop_clock_request_n, sleep_request_n, deep_sleep_request_n, grant_ack_resp, grant_ack_req;
  logic core_clk_en, wake_service, pending_break_n, power_status_n;
  logic [1:0] local_interrupt_lines, target;
  logic [2:0] resp_wait;
  lps_pkg::events_s wake_events, mask;
  lps_pkg::buf_en_s buf_en;
  lps_pkg::pstate_e state;
  int err_count = 0, checked = 0, seed = 32'hb033ea97, n;

  low_power_state_controller low_power_state_controller_inst (.clk, .resetn, .ce(1'b1), .halt_exec,
    .stop_clock_request_n, .sleep_request_n, .deep_sleep_request_n, .sys_mgmt_interrupt_n, .init_request_n,
    .local_interrupt_lines, .bus_int_msg, .snoop_seen, .snoop_done, .grant_ack_resp, .interrupt_enable_flag,
    .data_buffer_power_n, .priority_bus_request_n, .grant_ack_req, .core_clk_en, .wake_service,
    .wake_events, .pending_break_n, .power_status_n, .buf_en, .state);
  lps_chipset lps_chipset_inst (.clk, .resetn, .target, .resp_wait, .grant_ack_req, .power_status_n, .state,
    .stop_clock_request_n, .sleep_request_n, .deep_sleep_request_n, .grant_ack_resp, .clk_run);

  // bus clock, stands low while stopped
  initial
  begin
    clk = 1'b0;
    forever #50 if (clk_run || clk) clk = ~clk;
  end

  // watchdog against a stalled clock or a hung wait
  initial
  begin
    #5000000;
    err_count++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    wrap_up();
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_b(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_ev(input lps_pkg::events_s exp, input lps_pkg::events_s got);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED wake_events expected %h seen %h", exp, got);
    end
  endtask

  task automatic wait_st(input lps_pkg::pstate_e s, input int lim);
    int i;
    for (i = 0; i < lim && state !== s; i++) @(posedge clk) #1;
    checked++;
    if (state !== s)
    begin
      err_count++;
      $display("CHECK FAILED state expected %s seen %s", s.name(), state.name());
      wrap_up();
    end
  endtask

  function automatic lps_pkg::events_s ev_of(input int k);
    return lps_pkg::events_s'(5'h01 << k);
  endfunction

  // one wake source: 0 smi, 1 init, 2 and 3 local lines, 4 bus message
  task automatic fire(input int k);
    @(posedge clk)
    begin
      sys_mgmt_interrupt_n <= (k != 0);
      init_request_n <= (k != 1);
      local_interrupt_lines <= {k == 3, k == 2};
      bus_int_msg <= (k == 4);
    end
    @(posedge clk) bus_int_msg <= 1'b0;
    repeat (3) @(posedge clk);
    {sys_mgmt_interrupt_n, init_request_n, local_interrupt_lines} <= 4'hc;
    repeat (3) @(posedge clk);
  endtask

  task automatic halt;
    @(posedge clk) halt_exec <= 1'b1;
    @(posedge clk) halt_exec <= 1'b0;
  endtask

  task automatic snoop(input lps_pkg::pstate_e org);
    @(posedge clk) snoop_seen <= 1'b1;
    @(posedge clk) snoop_seen <= 1'b0;
    #1 chk_b("in_snoop", 1'b1, state == lps_pkg::st_snoop);
    @(posedge clk) snoop_done <= 1'b1;
    @(posedge clk) snoop_done <= 1'b0;
    #1 chk_b("snoop_back", 1'b1, state == org);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {resetn, halt_exec, bus_int_msg, snoop_seen, snoop_done, interrupt_enable_flag} = 6'h0;
    {sys_mgmt_interrupt_n, init_request_n, data_buffer_power_n, priority_bus_request_n} = 4'hf;
    {local_interrupt_lines, target, resp_wait} = 7'h0;
    mask = '0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    #1 chk_b("status_idle", 1'b1, power_status_n);
    chk_b("break_idle", 1'b1, pending_break_n);
    chk_b("core_clk_run", 1'b1, core_clk_en);
    for (int k = 0; k < 5; k++)
    begin
      halt();
      #1 chk_b("halted", 1'b1, state == lps_pkg::st_halt);
      if (k == 0) snoop(lps_pkg::st_halt);
      fire(k);
      wait_st(lps_pkg::st_normal, 1);
    end
    halt();
    target <= 2'h1;
    wait_st(lps_pkg::st_stop_grant, 60);
    @(posedge clk) target <= 2'h0;
    wait_st(lps_pkg::st_halt, 40);
    fire(4);
    for (int r = 0; r < 3; r++)
    begin
      mask = '0;
      @(posedge clk)
      begin
        target <= 2'h1;
        resp_wait <= 3'($random(seed));
        interrupt_enable_flag <= 1'($random(seed));
      end
      wait_st(lps_pkg::st_stop_grant, 60);
      for (int k = 0; k < 5; k++)
        if (($random(seed) & 1) != 0 || k == r)
        begin
          fire(k);
          fire(k);
          mask = mask | ev_of(k);
        end
      if (r == 0) snoop(lps_pkg::st_stop_grant);
      @(posedge clk) #1 chk_b("break", 1'b0, pending_break_n);
      @(posedge clk) target <= 2'h0;
      for (n = 0; n < 60 && wake_service !== 1'b1; n++) @(posedge clk) #1;
      chk_b("wake_service", 1'b1, wake_service);
      if (wake_service !== 1'b1) wrap_up();
      chk_ev(mask, wake_events);
      wait_st(lps_pkg::st_normal, 1);
      @(posedge clk) #1 chk_b("once", 1'b0, wake_service);
    end
    @(posedge clk) target <= 2'h3;
    wait_st(lps_pkg::st_sleep, 80);
    chk_b("core_clk_sleep", 1'b0, core_clk_en);
    wait_st(lps_pkg::st_deep_sleep, 20);
    chk_b("status_low", 1'b0, power_status_n);
    chk_b("core_clk", 1'b0, core_clk_en);
    #2000 chk_b("bclk_still", 1'b0, clk);
    target = 2'h1;
    wait_st(lps_pkg::st_pll_settle, 20);
    chk_b("status_high", 1'b1, power_status_n);
    for (n = 0; n < 400 && state === lps_pkg::st_pll_settle; n++) @(posedge clk) #1;
    chk_b("settle", 1'b1, n >= `LPS_PLL_SETTLE_CLKS && n <= `LPS_PLL_SETTLE_CLKS + 1);
    wait_st(lps_pkg::st_stop_grant, 40);
    @(posedge clk) target <= 2'h2;
    wait_st(lps_pkg::st_sleep, 40);
    @(posedge clk) {target, resetn} <= 3'h0;
    repeat (3) @(posedge clk);
    #1 chk_b("reset_sleep", 1'b1, state == lps_pkg::st_normal);
    @(posedge clk) resetn <= 1'b1;
    repeat (20)
    begin
      @(posedge clk) {data_buffer_power_n, priority_bus_request_n} <= 2'($random(seed));
      repeat (4) @(posedge clk);
      #1 chk_b("data_en", !data_buffer_power_n, buf_en.data_in_en);
      chk_b("addr_en", !priority_bus_request_n, buf_en.addr_ctl_in_en);
    end
    wrap_up();
  end
endmodule // tb

bind low_power_state_controller lps_checker lps_checker_inst (.clk, .resetn, .halt_exec, .bus_int_msg,
  .snoop_seen, .grant_ack_resp, .grant_ack_req, .data_buffer_power_n, .priority_bus_request_n,
  .wake_service, .wake_events, .pending_break_n, .power_status_n, .buf_en, .state);

`default_nettype wire
